// ==== core/nmr_consts.svh ====
// register offsets, field positions, command codes and reset values for the native max readback
`ifndef NMR_CONSTS_SVH
`define NMR_CONSTS_SVH
`define NMR_OFF_SECNUM 12'h000
`define NMR_OFF_CYLLO 12'h004
`define NMR_OFF_CYLHI 12'h008
`define NMR_OFF_DEVHEAD 12'h00C
`define NMR_OFF_COMMAND 12'h010
`define NMR_OFF_ERROR 12'h014
`define NMR_OFF_STATUS 12'h018
`define NMR_OFF_CTRL 12'h01C
`define NMR_OFF_NATLO 12'h020
`define NMR_OFF_NATHI 12'h024
`define NMR_OFF_IRQ_STAT 12'h028
`define NMR_OFF_IRQ_CLR 12'h02C
`define NMR_OFF_IRQ_EN 12'h030
`define NMR_OFF_CHS 12'h034
`define NMR_CMD_NATIVE28 8'hF8
`define NMR_CMD_NATIVE48 8'h27
`define NMR_LBA28_CAP 48'h00000FFFFFFF
`define NMR_DH_LBA_BIT 6
`define NMR_ERR_ABORT_BIT 2
`define NMR_ST_BUSY_BIT 7
`define NMR_ST_READY_BIT 6
`define NMR_ST_FAULT_BIT 5
`define NMR_ST_SEEK_BIT 4
`define NMR_ST_XFER_BIT 3
`define NMR_ST_ERR_BIT 0
`define NMR_CTRL_UPPER_BIT 0
`define NMR_CTRL_REJECT_BIT 1
`define NMR_IRQ_DONE_BIT 0
`define NMR_IRQ_ABORT_BIT 1
`define NMR_NATIVE_RESET 48'h000000FFFFFF
`define NMR_CHS_RESET 32'h3FFF0F3F
`define NMR_DEVHEAD_RESET 8'hA0
`endif

// ==== core/nmr_pkg.sv ====
// types shared by the native max readback block
package nmr_pkg;
   typedef enum logic [1:0] {NMR_IDLE, NMR_EXEC, NMR_DONE} nmr_state_type;
   typedef enum logic [1:0] {NMR_Q_NONE, NMR_Q_28, NMR_Q_48} nmr_query_type;
endpackage

// ==== core/nmr_result_latch.sv ====
// registered result latch: holds the returned address block bytes
`timescale 1ns/1ns
module nmr_result_latch
   import nmr_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // load
   input wire logic load,
   input wire logic [47:0] addr_in,
   input wire logic [3:0] head_in,
   // held result
   output logic [47:0] addr_q,
   output logic [3:0] head_q
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= 48'h000000000000;
         head_q <= 4'h0;
      end else if (load) begin
         addr_q <= addr_in;
         head_q <= head_in;
      end
   end
endmodule

// ==== core/nmr_native_max.sv ====
// task-file command handler for the two native max address queries, apb slave
`timescale 1ns/1ns
`include "nmr_consts.svh"
// Contract
// RL1 - command F8 starts the 28-bit native max query
// RL2 - command 27 starts the 48-bit native max query
// RL3 - 28-bit query reports true native max, ignoring any set-max limit
// RL4 - 48-bit query reports native max, ignoring any set-max limit
// RL5 - 28-bit query clamps to 268,435,455 when native max is larger
// RL6 - 28-bit logical mode: bits 0-7 go to sector number
// RL7 - 28-bit logical mode: bits 8-15 cylinder low, 16-23 cylinder high
// RL8 - 28-bit logical mode: bits 24-27 go to head field
// RL9 - cylinder/head/sector mode returns native max sector, cylinder, head
// RL10 - 48-bit: sector number gives 7:0, or 31:24 with upper readback
// RL11 - 48-bit: cylinder low gives 15:8, or 39:32 with upper readback
// RL12 - 48-bit: cylinder high gives 23:16, or 47:40 with upper readback
// RL13 - rejected query sets abort and error flag, others zero, busy clear
module nmr_native_max
   import nmr_pkg::*;
(
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq
);
   nmr_state_type state_r;
   nmr_query_type query_r;
   logic [47:0] native_r;
   logic [31:0] chs_r;
   logic [7:0] devhead_r;
   logic [7:0] error_r;
   logic [7:0] status_r;
   logic upper_byte_readback_r;
   logic reject_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_en_r;
   logic [47:0] result_nxt;
   logic [3:0] head_nxt;
   logic [47:0] result_q;
   logic [3:0] head_q;
   logic lba_mode;
   logic wr_en;
   logic rd_en;
   logic cmd_wr;
   logic ev_done;
   logic ev_abort;
   logic load_result;

   // a register is hit on an address match alone; callers add the apb phase (access for writes, setup for reads)
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, `NMR_OFF_SECNUM) || hit(a, `NMR_OFF_CYLLO) ||
               hit(a, `NMR_OFF_CYLHI) || hit(a, `NMR_OFF_DEVHEAD) ||
               hit(a, `NMR_OFF_COMMAND) || hit(a, `NMR_OFF_ERROR) ||
               hit(a, `NMR_OFF_STATUS) || hit(a, `NMR_OFF_CTRL) ||
               hit(a, `NMR_OFF_NATLO) || hit(a, `NMR_OFF_NATHI) ||
               hit(a, `NMR_OFF_IRQ_STAT) || hit(a, `NMR_OFF_IRQ_CLR) ||
               hit(a, `NMR_OFF_IRQ_EN) || hit(a, `NMR_OFF_CHS);
   endfunction

   // zero wait states: every access completes in its first access cycle
   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped(paddr);
   assign wr_en = psel && penable && pwrite && mapped(paddr);
   assign rd_en = psel && penable && !pwrite;
   // commands are taken only while idle; a write while busy is ignored
   assign cmd_wr = wr_en && hit(paddr, `NMR_OFF_COMMAND) && (state_r == NMR_IDLE);
   assign lba_mode = devhead_r[`NMR_DH_LBA_BIT];
   assign ev_done = (state_r == NMR_EXEC) && !reject_r;
   assign ev_abort = (state_r == NMR_EXEC) && reject_r;
   assign load_result = ev_done;

   // command recognition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= NMR_IDLE;
         query_r <= NMR_Q_NONE;
      end else begin
         case (state_r)
            NMR_IDLE: begin
               if (cmd_wr) begin
                  if (pwdata[7:0] == `NMR_CMD_NATIVE28) begin
                     state_r <= NMR_EXEC; // RL1
                     query_r <= NMR_Q_28;
                  end else if (pwdata[7:0] == `NMR_CMD_NATIVE48) begin
                     state_r <= NMR_EXEC; // RL2
                     query_r <= NMR_Q_48;
                  end
               end
            end
            NMR_EXEC: state_r <= NMR_DONE;
            NMR_DONE: state_r <= NMR_IDLE;
            default: state_r <= NMR_IDLE;
         endcase
      end
   end

   // result composition; native_r is the untouched native capacity, so any
   // set-max limit held elsewhere never reaches these bytes
   always_comb begin
      result_nxt = native_r; // RL4
      head_nxt = 4'h0;
      if (query_r == NMR_Q_28) begin
         if (!lba_mode) begin
            // sector in byte 0, cylinder in bytes 1-2, head in head field
            result_nxt = {24'h000000, chs_r[31:16], chs_r[7:0]}; // RL9
            head_nxt = chs_r[11:8]; // RL9
         end else begin
            if (native_r > `NMR_LBA28_CAP) begin
               result_nxt = `NMR_LBA28_CAP; // RL5
            end else begin
               result_nxt = native_r; // RL3
            end
            head_nxt = result_nxt[27:24]; // RL8
         end
      end
   end

   nmr_result_latch nmr_result_latch_inst (
      .pclk(pclk),
      .presetn(presetn),
      .load(load_result),
      .addr_in(result_nxt),
      .head_in(head_nxt),
      .addr_q(result_q),
      .head_q(head_q)
   );

   // configuration registers written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         native_r <= `NMR_NATIVE_RESET;
         chs_r <= `NMR_CHS_RESET;
         upper_byte_readback_r <= 1'b0;
         reject_r <= 1'b0;
         irq_en_r <= 2'h0;
      end else if (wr_en) begin
         if (hit(paddr, `NMR_OFF_NATLO)) begin
            native_r[31:0] <= pwdata;
         end
         if (hit(paddr, `NMR_OFF_NATHI)) begin
            native_r[47:32] <= pwdata[15:0];
         end
         if (hit(paddr, `NMR_OFF_CHS)) begin
            chs_r <= pwdata;
         end
         if (hit(paddr, `NMR_OFF_CTRL)) begin
            upper_byte_readback_r <= pwdata[`NMR_CTRL_UPPER_BIT];
            reject_r <= pwdata[`NMR_CTRL_REJECT_BIT];
         end
         if (hit(paddr, `NMR_OFF_IRQ_EN)) begin
            irq_en_r <= pwdata[1:0];
         end
      end
   end

   // device/head: host writes the whole byte while idle, the device returns the head after a 28-bit query
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         devhead_r <= `NMR_DEVHEAD_RESET;
      end else if (wr_en && hit(paddr, `NMR_OFF_DEVHEAD) && state_r == NMR_IDLE) begin
         devhead_r <= pwdata[7:0];
      end else if (state_r == NMR_DONE && !reject_r && query_r == NMR_Q_28) begin
         devhead_r[3:0] <= head_q; // RL8
      end
   end

   // error and status after each command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_r <= 8'h00;
         status_r <= 8'h50;
      end else if (cmd_wr) begin
         error_r <= 8'h00;
         status_r <= 8'h00;
         status_r[`NMR_ST_BUSY_BIT] <= 1'b1;
      end else if (ev_abort) begin
         error_r <= 8'h00;
         error_r[`NMR_ERR_ABORT_BIT] <= 1'b1; // RL13
         status_r <= 8'h00;
         status_r[`NMR_ST_READY_BIT] <= 1'b1;
         status_r[`NMR_ST_ERR_BIT] <= 1'b1; // RL13
      end else if (ev_done) begin
         error_r <= 8'h00;
         status_r <= 8'h00;
         status_r[`NMR_ST_READY_BIT] <= 1'b1;
         status_r[`NMR_ST_SEEK_BIT] <= 1'b1;
      end
   end

   // sticky events: a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == `NMR_IRQ_DONE_BIT && ev_done) || (i == `NMR_IRQ_ABORT_BIT && ev_abort)) begin
               irq_stat_r[i] <= 1'b1;
            end else if (wr_en && hit(paddr, `NMR_OFF_IRQ_CLR) && pwdata[i]) begin
               irq_stat_r[i] <= 1'b0;
            end
         end
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);

   // read data registered in the access cycle would be late, so the mux is
   // registered off the setup phase instead
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h00000000;
         if (hit(paddr, `NMR_OFF_SECNUM)) begin
            prdata[7:0] <= upper_byte_readback_r && query_r == NMR_Q_48 ?
                           result_q[31:24] : result_q[7:0]; // RL6 RL10
         end
         if (hit(paddr, `NMR_OFF_CYLLO)) begin
            prdata[7:0] <= upper_byte_readback_r && query_r == NMR_Q_48 ?
                           result_q[39:32] : result_q[15:8]; // RL7 RL11
         end
         if (hit(paddr, `NMR_OFF_CYLHI)) begin
            prdata[7:0] <= upper_byte_readback_r && query_r == NMR_Q_48 ?
                           result_q[47:40] : result_q[23:16]; // RL7 RL12
         end
         if (hit(paddr, `NMR_OFF_DEVHEAD)) begin
            prdata[7:0] <= devhead_r;
         end
         if (hit(paddr, `NMR_OFF_ERROR)) begin
            prdata[7:0] <= error_r;
         end
         if (hit(paddr, `NMR_OFF_STATUS)) begin
            prdata[7:0] <= status_r;
         end
         if (hit(paddr, `NMR_OFF_CTRL)) begin
            prdata[1:0] <= {reject_r, upper_byte_readback_r};
         end
         if (hit(paddr, `NMR_OFF_NATLO)) begin
            prdata <= native_r[31:0];
         end
         if (hit(paddr, `NMR_OFF_NATHI)) begin
            prdata[15:0] <= native_r[47:32];
         end
         if (hit(paddr, `NMR_OFF_IRQ_STAT)) begin
            prdata[1:0] <= irq_stat_r;
         end
         if (hit(paddr, `NMR_OFF_IRQ_EN)) begin
            prdata[1:0] <= irq_en_r;
         end
         if (hit(paddr, `NMR_OFF_CHS)) begin
            prdata <= chs_r;
         end
      end
   end

   // rd_en kept for clarity of the bus decode; reads have no side effects
   logic unused_rd;
   assign unused_rd = rd_en;
endmodule

// ==== verif/nmr_native_max_properties.sv ====
// assertions on the apb ports of the native max readback block
`timescale 1ns/1ns
module nmr_native_max_properties (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // interrupt
   input wire logic irq
);
   logic [1:0] cnt_r;
   logic en_r;
   wire acc = psel & penable;
   wire wr_acc = acc & pwrite;
   wire rd_acc = acc & !pwrite;
   wire cmd_go = wr_acc && paddr == 12'h010 && (pwdata[7:0] == 8'hF8 || pwdata[7:0] == 8'h27);
   // wider than the real busy span, so a reload on an ignored write only adds slack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_r <= 2'h0;
      else if (cmd_go) cnt_r <= 2'h3;
      else if (cnt_r != 2'h0) cnt_r <= cnt_r - 2'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) en_r <= 1'b0;
      else if (wr_acc && paddr == 12'h030) en_r <= |pwdata[1:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   zero_wait_a: assert property ($rose(penable) && psel |-> pready)
      else $error("pready missing in access phase");
   bus_idle_a: assert property (!psel |-> !pready && !pslverr)
      else $error("answer without select");
   unmapped_err_a: assert property (acc && paddr > 12'h034 |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (acc && paddr <= 12'h034 |-> !pslverr)
      else $error("mapped access refused");
   status_ok_a: assert property (rd_acc && paddr == 12'h018 && cnt_r == 2'h0 |-> prdata[7:5] == 3'h2)
      else $error("status busy or fault when idle");
   err_only_abort_a: assert property (rd_acc && paddr == 12'h014 |-> (prdata[7:0] & 8'hFB) == 8'h00)
      else $error("error bit other than abort set");
   irq_masked_a: assert property (!en_r |-> !irq)
      else $error("irq while all sources disabled");
   clear_drop_a: assert property (wr_acc && paddr == 12'h02C && pwdata[1:0] == 2'h3 && cnt_r == 2'h0 |=> !irq)
      else $error("irq stays after full clear");
   cover property (cmd_go && pwdata[7:0] == 8'hF8);
   cover property (cmd_go && pwdata[7:0] == 8'h27);
   cover property (pslverr);
   cover property ($rose(irq));
endmodule
bind nmr_native_max nmr_native_max_properties nmr_native_max_properties_inst (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ==== verif/nmr_host_model.sv ====
// apb host model issuing task-file register accesses
`timescale 1ns/1ns
module nmr_host_model (
   // clock
   input wire logic pclk,
   // apb master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      // released lines show the inverse so a stale value never looks valid
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// ==== verif/tb_nmr_native_max.sv ====
// self-checking bench for the native max readback block
`timescale 1ns/1ns
module tb_nmr_native_max;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [47:0] v;
   int n_errors, compares;
   nmr_native_max nmr_native_max_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq));
   nmr_host_model nmr_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task results;
      if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string s, input logic [7:0] x, input logic [7:0] g);
      compares++;
      if (g !== x) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", s, x, g);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      nmr_host_model_inst.xfer(1'b1, a, d, q, e);
   endtask
   task rdc(input logic [11:0] a, input logic [7:0] x, input string s);
      nmr_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
      chk(s, x, q[7:0]);
   endtask
   // polls busy under a bound; the design needs only two cycles
   task cmd(input logic [7:0] c);
      int i;
      i = 0;
      wr(12'h010, {24'h0, c});
      do nmr_host_model_inst.xfer(1'b0, 12'h018, 32'h0, q, e);
      while (q[7] !== 1'b0 && ++i < 20);
      chk("busy_end", 8'h00, {7'h0, q[7]});
   endtask
   task t_lba28(input logic [27:0] n, input logic [27:0] x);
      wr(12'h020, {4'h0, n});
      wr(12'h024, 32'h0);
      wr(12'h01C, 32'h1);
      wr(12'h00C, 32'h40);
      cmd(8'hF8);
      rdc(12'h000, x[7:0], "sector");
      rdc(12'h004, x[15:8], "cyl_low");
      rdc(12'h008, x[23:16], "cyl_high");
      rdc(12'h00C, {4'h4, x[27:24]}, "head");
   endtask
   task t_chs;
      wr(12'h034, 32'h12340567);
      wr(12'h00C, 32'hA0);
      cmd(8'hF8);
      rdc(12'h000, 8'h67, "chs_sector");
      rdc(12'h004, 8'h34, "chs_cyl_low");
      rdc(12'h008, 8'h12, "chs_cyl_high");
      rdc(12'h00C, 8'hA5, "chs_head");
   endtask
   task t_lba48;
      v = 48'h0123456789AB;
      wr(12'h020, v[31:0]);
      wr(12'h024, {16'h0, v[47:32]});
      cmd(8'h27);
      for (int h = 0; h < 2; h++) begin
         wr(12'h01C, h);
         for (int i = 0; i < 3; i++) rdc(12'(i * 4), v[8 * (i + 3 * h) +: 8], "lba48");
      end
   endtask
   task t_reject;
      wr(12'h02C, 32'h3);
      wr(12'h030, 32'h2);
      wr(12'h01C, 32'h2);
      cmd(8'hF8);
      rdc(12'h014, 8'h04, "error");
      rdc(12'h018, 8'h41, "status");
      #1 chk("irq", 8'h01, {7'h0, irq});
      wr(12'h030, 32'h0);
      #1 chk("irq_masked", 8'h00, {7'h0, irq});
      wr(12'h030, 32'h2);
      #1 chk("irq_unmasked", 8'h01, {7'h0, irq});
      wr(12'h02C, 32'h2);
      #1 chk("irq_cleared", 8'h00, {7'h0, irq});
      rdc(12'h028, 8'h00, "irq_stat");
      wr(12'h01C, 32'h0);
   endtask
   initial begin
      n_errors = 0;
      compares = 0;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(12'h018, 8'h50, "reset_status");
      rdc(12'h014, 8'h00, "reset_error");
      rdc(12'h00C, 8'hA0, "reset_dev_head");
      t_lba28(28'hA1B2C3D, 28'hA1B2C3D);
      t_lba28(28'hFFFFFFF, 28'hFFFFFFF);
      wr(12'h024, 32'h0);
      t_lba28(28'h0, 28'h0);
      t_chs;
      t_lba48;
      wr(12'h024, 32'h1);
      wr(12'h00C, 32'h40);
      cmd(8'hF8);
      rdc(12'h008, 8'hFF, "clamp_cyl_high");
      rdc(12'h00C, 8'h4F, "clamp_head");
      t_reject;
      rdc(12'h040, 8'h00, "unmapped_data");
      chk("unmapped_err", 8'h01, {7'h0, e});
      results;
   end
   initial begin
      #20000;
      n_errors++;
      results;
   end
endmodule
